// ===== src/vtd_pkg.sv
// package: register map, field positions and reset values of the voltage threshold detector
package vtd_pkg;

    // ****************************************
    // register byte offsets
    // ****************************************
    localparam logic [3:0] VTD_OFS_CONTROL = 4'h0;
    localparam logic [3:0] VTD_OFS_IRQCTL = 4'h4;
    localparam logic [3:0] VTD_OFS_FLAG = 4'h8;
    localparam logic [3:0] VTD_OFS_ENABLE = 4'hc;

    // ****************************************
    // control register fields
    // ****************************************
    localparam int VTD_CTL_DIR_BIT = 7;
    localparam int VTD_CTL_STABLE_BIT = 5;
    localparam int VTD_CTL_EN_BIT = 4;
    localparam int VTD_CTL_LEVEL_LSB = 0;
    localparam int VTD_CTL_LEVEL_W = 4;
    localparam logic [3:0] VTD_LEVEL_EXTERNAL = 4'hf;
    localparam logic [3:0] VTD_LEVEL_RESET = 4'h5;
    localparam logic VTD_DIR_RESET = 1'b0;

    // ****************************************
    // irq control and peripheral register fields
    // ****************************************
    localparam int VTD_GIE_BIT = 7;
    localparam int VTD_DETECT_BIT = 2;
    localparam logic [7:0] VTD_IRQCTL_RESET = 8'h00;

    // ****************************************
    // bus responses
    // ****************************************
    localparam logic [1:0] VTD_RESP_OKAY = 2'b00;
    localparam logic [1:0] VTD_RESP_SLVERR = 2'b10;

    typedef enum logic [2:0]
    {
        VTD_ST_OFF = 3'b001,
        VTD_ST_SETTLE = 3'b010,
        VTD_ST_ARMED = 3'b100
    } vtd_state_e;

endpackage : vtd_pkg

// ===== src/vtd_sync.sv
// two-stage synchroniser for asynchronous levels
`timescale 1ns/1ps
module vtd_sync
    import vtd_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    if (WIDTH < 1)
    begin : g_width_check
        $error("vtd_sync: WIDTH must be at least 1");
    end

    typedef struct packed
    {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } vtd_sync_s;

    vtd_sync_s state_reg;
    vtd_sync_s state_next;

    always_comb
    begin
        state_next = state_reg;
        if (aclk_en)
        begin
            state_next.first = async_in;
            state_next.second = state_reg.first;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            state_reg <= '0;
        else
            state_reg <= state_next;
    end

    assign sync_out = state_reg.second;

endmodule : vtd_sync

// ===== src/vtd_top.sv
// voltage threshold detector control, flag and wake logic with an axi4-lite register slave
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// - four-bit trip level selects fifteen thresholds
// - all-ones level selects the external trip input
// - comparator trip sets the detect flag
// - no flag until reference settling has finished
// - settling timed by external settled indication
// - no interrupt while reference stable is clear
// - detector keeps working during sleep
// - trip in sleep sets flag, requests wake
// - vector after wake only with global enable
// - reset restores registers, detector disabled
// - shared reference off forces fresh settling
// - direction picks rising or falling event
// - stable bit is read-only settled status
// - each enable restarts settling wait
module vtd_top
    import vtd_pkg::*;
#(
    parameter int ADDR_W = 4
)
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic comparator_above,
    input wire logic reference_settled,
    input wire logic reference_shared_on,
    input wire logic sleep_active,
    output logic detector_power_on,
    output logic [3:0] trip_level_select,
    output logic external_trip_input_select,
    output logic detect_irq,
    output logic detect_irq_high_priority,
    output logic wake_request
);

    // refused at elaboration: the word decoder reads address bits 3:2
    if (ADDR_W < 4)
    begin : g_addr_w_check
        $error("vtd_top: ADDR_W must be at least 4");
    end

    // ****************************************
    // state
    // ****************************************
    typedef struct packed
    {
        vtd_state_e fsm;
        logic direction_select;
        logic detector_enable;
        logic [3:0] trip_level_select;
        logic global_irq_enable;
        logic [6:0] irq_ctl_other;
        logic detect_flag;
        logic detect_irq_enable;
        logic detect_priority;
        logic aw_held;
        logic [ADDR_W-1:0] aw_addr;
        logic w_held;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic power_on;
        logic [3:0] level_out;
        logic ext_sel;
        logic irq;
        logic irq_high;
        logic wake;
    } vtd_s;

    vtd_s st_reg;
    vtd_s st_next;
    logic [1:0] sync_q;
    logic cmp_sync;
    logic settled_sync;

    vtd_sync #(
        .WIDTH(2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .aclk_en(aclk_en),
        .async_in({reference_settled, comparator_above}),
        .sync_out(sync_q)
    );
    assign cmp_sync = sync_q[0];
    assign settled_sync = sync_q[1];

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [31:0] data, input logic [3:0] strb);
        merge_byte = strb[0] ? data[7:0] : old_v;
    endfunction : merge_byte

    function automatic logic [1:0] word_index(input logic [ADDR_W-1:0] addr);
        word_index = addr[3:2];
    endfunction : word_index

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
        logic hi_zero;
        hi_zero = 1'b1;
        for (int i = 4; i < ADDR_W; i++)
            if (addr[i])
                hi_zero = 1'b0;
        addr_mapped = hi_zero && (addr[1:0] == 2'b00);
    endfunction : addr_mapped

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb
    begin
        logic stable;
        logic event_hit;
        logic hw_set;
        logic do_write;
        logic [7:0] wbyte;
        logic [7:0] rbyte;
        logic [ADDR_W-1:0] waddr;
        stable = 1'b0;
        event_hit = 1'b0;
        hw_set = 1'b0;
        do_write = 1'b0;
        wbyte = 8'h00;
        rbyte = 8'h00;
        waddr = '0;
        st_next = st_reg;
        if (aclk_en)
        begin
            stable = (st_reg.fsm == VTD_ST_ARMED);
            // direction: 1 watches at-or-above, 0 strictly below
            event_hit = st_reg.direction_select ? cmp_sync : !cmp_sync;
            hw_set = stable && event_hit;

            // settling sequence; dropping enable or the shared reference forces a new wait
            unique case (st_reg.fsm)
                VTD_ST_OFF:
                begin
                    if (st_reg.detector_enable)
                        st_next.fsm = VTD_ST_SETTLE;
                end
                VTD_ST_SETTLE:
                begin
                    if (!st_reg.detector_enable)
                        st_next.fsm = VTD_ST_OFF;
                    else if (settled_sync)
                        st_next.fsm = VTD_ST_ARMED;
                end
                VTD_ST_ARMED:
                begin
                    if (!st_reg.detector_enable)
                        st_next.fsm = VTD_ST_OFF;
                    else if (!settled_sync && !reference_shared_on)
                        st_next.fsm = VTD_ST_SETTLE;
                end
                default:
                    st_next.fsm = VTD_ST_OFF;
            endcase

            // write channel: address and data captured in either order
            if (s_axi_awvalid && st_reg.awready)
            begin
                st_next.aw_held = 1'b1;
                st_next.aw_addr = s_axi_awaddr;
                st_next.awready = 1'b0;
            end
            if (s_axi_wvalid && st_reg.wready)
            begin
                st_next.w_held = 1'b1;
                st_next.w_data = s_axi_wdata;
                st_next.w_strb = s_axi_wstrb;
                st_next.wready = 1'b0;
            end
            if (st_reg.aw_held && st_reg.w_held && !st_reg.bvalid)
            begin
                waddr = st_reg.aw_addr;
                do_write = addr_mapped(waddr);
                st_next.aw_held = 1'b0;
                st_next.w_held = 1'b0;
                st_next.bvalid = 1'b1;
                st_next.bresp = do_write ? VTD_RESP_OKAY : VTD_RESP_SLVERR;
            end
            if (st_reg.bvalid && s_axi_bready)
            begin
                st_next.bvalid = 1'b0;
                st_next.awready = 1'b1;
                st_next.wready = 1'b1;
            end

            if (do_write)
            begin
                unique case (word_index(waddr))
                    2'd0:
                    begin
                        wbyte = merge_byte({st_reg.direction_select, 2'b00, st_reg.detector_enable,
                            st_reg.trip_level_select}, st_reg.w_data, st_reg.w_strb);
                        st_next.direction_select = wbyte[VTD_CTL_DIR_BIT];
                        st_next.detector_enable = wbyte[VTD_CTL_EN_BIT];
                        st_next.trip_level_select = wbyte[VTD_CTL_LEVEL_LSB +: VTD_CTL_LEVEL_W];
                        if (!wbyte[VTD_CTL_EN_BIT] || !st_reg.detector_enable)
                            st_next.fsm = VTD_ST_OFF;
                    end
                    2'd1:
                    begin
                        wbyte = merge_byte({st_reg.global_irq_enable, st_reg.irq_ctl_other},
                            st_reg.w_data, st_reg.w_strb);
                        st_next.global_irq_enable = wbyte[VTD_GIE_BIT];
                        st_next.irq_ctl_other = wbyte[6:0];
                    end
                    2'd2:
                    begin
                        wbyte = merge_byte({5'b0, st_reg.detect_flag, 2'b0}, st_reg.w_data, st_reg.w_strb);
                        st_next.detect_flag = wbyte[VTD_DETECT_BIT];
                    end
                    2'd3:
                    begin
                        wbyte = merge_byte({5'b0, st_reg.detect_irq_enable, 2'b0}, st_reg.w_data, st_reg.w_strb);
                        st_next.detect_irq_enable = wbyte[VTD_DETECT_BIT];
                        // priority shares the enable word, same bit position in the byte above the one holding the enable
                        if (st_reg.w_strb[1])
                            st_next.detect_priority = st_reg.w_data[8 + VTD_DETECT_BIT];
                    end
                    default:
                    begin
                    end
                endcase
            end

            // hardware set after software write so a same-cycle trip is kept
            if (hw_set)
                st_next.detect_flag = 1'b1;

            // read channel
            if (s_axi_arvalid && st_reg.arready)
            begin
                st_next.arready = 1'b0;
                st_next.rvalid = 1'b1;
                st_next.rresp = addr_mapped(s_axi_araddr) ? VTD_RESP_OKAY : VTD_RESP_SLVERR;
                unique case (word_index(s_axi_araddr))
                    2'd0:
                        rbyte = {st_reg.direction_select, 1'b0, stable, st_reg.detector_enable,
                            st_reg.trip_level_select};
                    2'd1:
                        rbyte = {st_reg.global_irq_enable, st_reg.irq_ctl_other};
                    2'd2:
                        rbyte = {5'b0, st_reg.detect_flag, 2'b0};
                    default:
                        rbyte = {5'b0, st_reg.detect_irq_enable, 2'b0};
                endcase
                st_next.rdata = 32'h0000_0000;
                if (addr_mapped(s_axi_araddr))
                begin
                    st_next.rdata[7:0] = rbyte;
                    if (word_index(s_axi_araddr) == 2'd3)
                        st_next.rdata[8 + VTD_DETECT_BIT] = st_reg.detect_priority;
                end
            end
            if (st_reg.rvalid && s_axi_rready)
            begin
                st_next.rvalid = 1'b0;
                st_next.arready = 1'b1;
            end

            // registered outputs toward the analog side and the core
            st_next.power_on = st_next.detector_enable;
            st_next.level_out = st_next.trip_level_select;
            st_next.ext_sel = (st_next.trip_level_select == VTD_LEVEL_EXTERNAL);
            // irq only from an armed detector, never during settling
            st_next.irq = st_next.detect_flag && st_next.detect_irq_enable
                && st_next.global_irq_enable && (st_next.fsm == VTD_ST_ARMED);
            st_next.irq_high = st_next.detect_priority;
            // wake is raised by a pending enabled flag while asleep, vector gating left to irq
            st_next.wake = sleep_active && st_next.detect_flag && st_next.detect_irq_enable
                && (st_next.fsm == VTD_ST_ARMED);
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_reg <= '0;
            st_reg.fsm <= VTD_ST_OFF;
            st_reg.direction_select <= VTD_DIR_RESET;
            st_reg.trip_level_select <= VTD_LEVEL_RESET;
            st_reg.level_out <= VTD_LEVEL_RESET;
            st_reg.irq_ctl_other <= VTD_IRQCTL_RESET[6:0];
            st_reg.awready <= 1'b1;
            st_reg.wready <= 1'b1;
            st_reg.arready <= 1'b1;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = st_reg.awready;
    assign s_axi_wready = st_reg.wready;
    assign s_axi_bvalid = st_reg.bvalid;
    assign s_axi_bresp = st_reg.bresp;
    assign s_axi_arready = st_reg.arready;
    assign s_axi_rvalid = st_reg.rvalid;
    assign s_axi_rdata = st_reg.rdata;
    assign s_axi_rresp = st_reg.rresp;
    assign detector_power_on = st_reg.power_on;
    assign trip_level_select = st_reg.level_out;
    assign external_trip_input_select = st_reg.ext_sel;
    assign detect_irq = st_reg.irq;
    assign detect_irq_high_priority = st_reg.irq_high;
    assign wake_request = st_reg.wake;

endmodule : vtd_top

// ===== verif/vtd_analog_model.sv
// behavioural supply rail, shared reference and trip comparator beside the detector
`timescale 1ns/1ps
module vtd_analog_model
#(
    parameter int SETTLE_NS = 300
)
(
    input wire logic detector_power_on,
    input wire logic reference_shared_on,
    input wire logic [3:0] trip_level_select,
    input wire logic external_trip_input_select,
    input wire logic [3:0] supply_level,
    input wire logic external_above,
    output logic comparator_above,
    output logic reference_settled
);
    // settling runs in ns, so it does not scale with the clock
    initial reference_settled = 1'b0;
    always
    begin
        wait (detector_power_on || reference_shared_on);
        #SETTLE_NS;
        reference_settled = detector_power_on || reference_shared_on;
        wait (!(detector_power_on || reference_shared_on));
        reference_settled = 1'b0;
    end
    assign comparator_above = external_trip_input_select ? external_above : (supply_level >= trip_level_select);
endmodule : vtd_analog_model

// ===== verif/vtd_top_sva.sv
// assertions on the detector outputs and its register bus handshake
`timescale 1ns/1ps
module vtd_top_sva
    import vtd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic aclk_en,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic sleep_active,
    input wire logic detector_power_on,
    input wire logic [3:0] trip_level_select,
    input wire logic external_trip_input_select,
    input wire logic detect_irq,
    input wire logic wake_request
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // ****************************************
    // properties
    // ****************************************
    property p_ext_sel;
        external_trip_input_select == (trip_level_select == VTD_LEVEL_EXTERNAL);
    endproperty
    property p_reset_vals;
        $rose(aresetn) |-> trip_level_select == VTD_LEVEL_RESET && !detector_power_on && !wake_request;
    endproperty
    property p_off_quiet;
        !detector_power_on [*3] |-> !detect_irq && !wake_request;
    endproperty
    // settling takes at least two sync edges, so no early interrupt
    property p_enable_settles;
        $rose(detector_power_on) |=> !detect_irq [*2];
    endproperty
    property p_wake_in_sleep;
        wake_request |-> $past(sleep_active);
    endproperty
    property p_write_lat;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && aclk_en |=> !s_axi_awready ##1 s_axi_bvalid;
    endproperty
    property p_read_lat;
        s_axi_arvalid && s_axi_arready && aclk_en |=> s_axi_rvalid && !s_axi_arready;
    endproperty
    property p_bhold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    property p_rhold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    // ****************************************
    // assertions and covers
    // ****************************************
    a_ext_sel: assert property (p_ext_sel) else $error("external select disagrees with level");
    a_reset_vals: assert property (p_reset_vals) else $error("bad values after reset");
    a_off_quiet: assert property (p_off_quiet) else $error("irq or wake while disabled");
    a_enable_settles: assert property (p_enable_settles) else $error("irq during settling");
    a_wake_in_sleep: assert property (p_wake_in_sleep) else $error("wake outside sleep");
    a_write_lat: assert property (p_write_lat) else $error("write response timing wrong");
    a_read_lat: assert property (p_read_lat) else $error("read response timing wrong");
    a_bhold: assert property (p_bhold) else $error("write response dropped");
    a_rhold: assert property (p_rhold) else $error("read data dropped");
    c_irq: cover property (detect_irq);
    c_wake: cover property (wake_request);
    c_ext: cover property (external_trip_input_select);
endmodule : vtd_top_sva

// ===== verif/test_voltage_threshold_detector.sv
// self-checking bench for the voltage threshold detector
`timescale 1ns/1ps
module test_voltage_threshold_detector
    import vtd_pkg::*;
;
    typedef struct {logic [3:0] a; logic [31:0] w; logic [31:0] r;} vtd_row_s;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, sleep_active = 1'b0;
    logic aclk_en = 1'b1, shared = 1'b0;
    logic [3:0] awaddr = 4'h0, araddr = 4'h0, sup = 4'h8;
    logic [31:0] wdata = 32'h0, d;
    logic [1:0] resp, bresp, rresp;
    logic awready, wready, bvalid, arready, rvalid, cmp, settled, pwr, ext, irq, prio, wake;
    logic [31:0] rdata;
    logic [3:0] trip;
    int err_total = 0, checked = 0, cyc = 0;
    vtd_row_s rows [6] = '{'{4'h0, 32'h8f, 32'h8f}, '{4'h0, 32'h2a, 32'h0a}, '{4'h4, 32'hff, 32'hff},
        '{4'h8, 32'h04, 32'h04}, '{4'h8, 32'h00, 32'h00}, '{4'hc, 32'h404, 32'h404}};

    vtd_top dut (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .comparator_above(cmp),
        .reference_settled(settled), .reference_shared_on(shared), .sleep_active(sleep_active),
        .detector_power_on(pwr), .trip_level_select(trip), .external_trip_input_select(ext), .detect_irq(irq),
        .detect_irq_high_priority(prio), .wake_request(wake));
    vtd_analog_model far (.detector_power_on(pwr), .reference_shared_on(shared), .trip_level_select(trip),
        .external_trip_input_select(ext), .supply_level(sup), .external_above(1'b1), .comparator_above(cmp),
        .reference_settled(settled));

    always #5 aclk = ~aclk;
    always @(posedge aclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            err_total++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // response ready offered with the request, dropped at the edge that takes the answer
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        resp = bresp;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        v = rdata;
        resp = rresp;
    endtask : rd

    task automatic rc(input logic [3:0] a, input logic [31:0] exp);
        rd(a, d);
        chk(d, exp);
    endtask : rc

    // comparator path is two sync edges, then one edge that sets the flag and the irq and wake outputs together
    task automatic setsup(input logic [3:0] v);
        sup <= v;
        repeat (8) @(posedge aclk);
    endtask : setsup

    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rc(4'h0, 32'h05);
        rc(4'h4, 32'h00);
        rc(4'h8, 32'h00);
        rc(4'hc, 32'h00);
        chk(32'(pwr), 32'h0);
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].w);
            rc(rows[i].a, rows[i].r);
        end
        chk(32'(prio), 32'h1);
        for (int i = 0; i < 16; i++)
        begin
            wr(4'h0, 32'(i));
            chk(32'(trip), 32'(i));
            chk(32'(ext), 32'(i == 15));
        end
        wr(4'h4, 32'h0);
        wr(4'h0, 32'h03);
        sup <= 4'h1;
        wr(4'h0, 32'h13);
        chk(32'(pwr), 32'h1);
        rc(4'h0, 32'h13);
        rc(4'h8, 32'h00);
        repeat (40) @(posedge aclk);
        rc(4'h0, 32'h33);
        rc(4'h8, 32'h04);
        wr(4'h8, 32'h0);
        rc(4'h8, 32'h04);
        setsup(4'h8);
        wr(4'h8, 32'h0);
        rc(4'h8, 32'h00);
        wr(4'h4, 32'h80);
        // frozen by the clock enable: the trip must not reach the flag
        aclk_en <= 1'b0;
        setsup(4'h1);
        chk(32'(irq), 32'h0);
        aclk_en <= 1'b1;
        setsup(4'h1);
        chk(32'(irq), 32'h1);
        wr(4'h4, 32'h0);
        setsup(4'h8);
        wr(4'h8, 32'h0);
        sleep_active <= 1'b1;
        setsup(4'h1);
        chk(32'(wake), 32'h1);
        chk(32'(irq), 32'h0);
        sleep_active <= 1'b0;
        wr(4'h0, 32'h93);
        wr(4'h8, 32'h0);
        rc(4'h8, 32'h00);
        setsup(4'h8);
        rc(4'h8, 32'h04);
        wr(4'h4, 32'h80);
        setsup(4'h8);
        chk(32'(irq), 32'h1);
        wr(4'h0, 32'h83);
        chk(32'(pwr), 32'h0);
        wr(4'h0, 32'h93);
        chk(32'(irq), 32'h0);
        rc(4'h0, 32'h93);
        repeat (40) @(posedge aclk);
        rc(4'h0, 32'hb3);
        // reference held by another user: re-enable arms without the long settling
        wr(4'h4, 32'h0);
        shared <= 1'b1;
        wr(4'h0, 32'h83);
        wr(4'h0, 32'h93);
        repeat (4) @(posedge aclk);
        rc(4'h0, 32'hb3);
        shared <= 1'b0;
        wr(4'h2, 32'h1);
        chk(32'(resp), 32'(VTD_RESP_SLVERR));
        rd(4'h1, d);
        chk(32'(resp), 32'(VTD_RESP_SLVERR));
        chk(d, 32'h0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rc(4'h0, 32'h05);
        rc(4'hc, 32'h00);
        print_verdict();
    end
endmodule : test_voltage_threshold_detector

bind vtd_top vtd_top_sva u_sva (.aclk(aclk), .aresetn(aresetn), .aclk_en(aclk_en), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sleep_active(sleep_active),
    .detector_power_on(detector_power_on), .trip_level_select(trip_level_select),
    .external_trip_input_select(external_trip_input_select), .detect_irq(detect_irq), .wake_request(wake_request));
